// >>> rtl/call_clear_watchdog_exec.sv
// Summary of operation
// - Call pushes program counter plus one, flags kept
// - Call then loads program counter with target
// - Call takes two instruction cycles
// - Byte clear writes zero, flags kept
// - Bit clear zeroes only selected bit
// - Single clear resets watchdog and both flags
// - First pre-clear acts only alternating with second
// - Second pre-clear acts only alternating with first
// - Repeated same pre-clear has no effect
// - Pre-clears clear flags only after a completed pair, unrelated work between allowed
`timescale 1ns/10ps
`default_nettype none

module call_clear_watchdog_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Decoded instruction
    input wire exec_pkg::instr_t instr,
    // Flag set events from the watchdog and power-down logic
    input wire logic timeout_set,
    input wire logic powerdown_set,
    // Sequencer status
    output logic busy,
    // Return stack push
    output logic stack_push,
    output logic [exec_pkg::PC_W-1:0] stack_data,
    // Program counter load
    output logic pc_load,
    output logic [exec_pkg::PC_W-1:0] pc_target,
    // Data memory write
    output exec_pkg::mem_wr_t mem_wr,
    // Watchdog control and status flags
    output logic watchdog_clear,
    output logic timeout_flag,
    output logic powerdown_flag
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------

    // Sequencer state; a call holds the unit for its second cycle.
    exec_pkg::exec_state_t state_reg;
    exec_pkg::exec_state_t state_next;
    // Call target, held across the two call cycles.
    logic [exec_pkg::PC_W-1:0] target_reg;
    logic [exec_pkg::PC_W-1:0] target_next;
    // Registered outputs.
    logic busy_reg;
    logic busy_next;
    logic push_reg;
    logic push_next;
    logic [exec_pkg::PC_W-1:0] push_data_reg;
    logic [exec_pkg::PC_W-1:0] push_data_next;
    logic load_reg;
    logic load_next;
    exec_pkg::mem_wr_t wr_reg;
    exec_pkg::mem_wr_t wr_next;
    logic wdt_clr_reg;
    logic wdt_clr_next;
    logic timeout_reg;
    logic timeout_next;
    logic powerdown_reg;
    logic powerdown_next;
    // An instruction is taken only while no call is in its second cycle.
    logic accept;
    // Pre-clear strobes and pair completion.
    logic first_strobe;
    logic second_strobe;
    logic pair_done;
    // Any source of a watchdog clear this cycle.
    logic clear_req;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------

    // The decode stage must hold off while busy; anything offered is ignored.
    assign accept = instr.valid && !busy_reg;
    assign first_strobe = accept && (instr.op == exec_pkg::OP_WDT_FIRST);
    assign second_strobe = accept && (instr.op == exec_pkg::OP_WDT_SECOND);

    // Alternation of the two pre-clear halves lives in its own tracker.
    preclear_tracker u_tracker (
        .clk(clk),
        .reset_n(reset_n),
        .first_strobe(first_strobe),
        .second_strobe(second_strobe),
        .pair_done(pair_done)
    );

    assign clear_req = (accept && (instr.op == exec_pkg::OP_WDT_SINGLE)) || pair_done;

    // ------------------------------------------------------------------
    // Sequencer and outputs
    // ------------------------------------------------------------------

    // Computes every next value but the flags; strobes default low each cycle.
    always_comb begin
        state_next = state_reg;
        target_next = target_reg;
        busy_next = 1'b0;
        push_next = 1'b0;
        push_data_next = push_data_reg;
        load_next = 1'b0;
        wr_next = wr_reg;
        wr_next.en = 1'b0;
        wdt_clr_next = clear_req;
        case (state_reg)
            exec_pkg::ST_IDLE: begin
                if (accept) begin
                    case (instr.op)
                        exec_pkg::OP_CALL: begin
                            push_next = 1'b1;
                            push_data_next = instr.pc + exec_pkg::RET_STEP;
                            target_next = instr.target;
                            busy_next = 1'b1;
                            state_next = exec_pkg::ST_CALL2;
                        end
                        exec_pkg::OP_CLR_BYTE: begin
                            wr_next.en = 1'b1;
                            wr_next.addr = instr.addr;
                            wr_next.mask = exec_pkg::FULL_MASK;
                            wr_next.data = exec_pkg::CLEAR_BYTE;
                        end
                        exec_pkg::OP_CLR_BIT: begin
                            wr_next.en = 1'b1;
                            wr_next.addr = instr.addr;
                            wr_next.mask = exec_pkg::BIT0_MASK << instr.bitsel;
                            wr_next.data = exec_pkg::CLEAR_BYTE;
                        end
                        default: begin
                            // Watchdog clears need no sequencing here.
                            state_next = exec_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            exec_pkg::ST_CALL2: begin
                load_next = 1'b1;
                state_next = exec_pkg::ST_IDLE;
            end
            default: begin
                state_next = exec_pkg::ST_IDLE;
            end
        endcase
    end

    // Flag next values. A set in the same cycle as a clear wins so that a
    // time-out or power-down event is never lost to a racing clear.
    always_comb begin
        timeout_next = timeout_reg;
        powerdown_next = powerdown_reg;
        if (clear_req) begin
            timeout_next = 1'b0;
            powerdown_next = 1'b0;
        end
        if (timeout_set) begin
            timeout_next = 1'b1;
        end
        if (powerdown_set) begin
            powerdown_next = 1'b1;
        end
    end

    // Registers all state and outputs.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= exec_pkg::ST_IDLE;
            target_reg <= '0;
            busy_reg <= 1'b0;
            push_reg <= 1'b0;
            push_data_reg <= '0;
            load_reg <= 1'b0;
            wr_reg <= '0;
            wdt_clr_reg <= 1'b0;
            timeout_reg <= exec_pkg::FLAG_RESET;
            powerdown_reg <= exec_pkg::FLAG_RESET;
        end else begin
            state_reg <= state_next;
            target_reg <= target_next;
            busy_reg <= busy_next;
            push_reg <= push_next;
            push_data_reg <= push_data_next;
            load_reg <= load_next;
            wr_reg <= wr_next;
            wdt_clr_reg <= wdt_clr_next;
            timeout_reg <= timeout_next;
            powerdown_reg <= powerdown_next;
        end
    end

    // Every output comes straight from a flip-flop.
    assign busy = busy_reg;
    assign stack_push = push_reg;
    assign stack_data = push_data_reg;
    assign pc_load = load_reg;
    assign pc_target = target_reg;
    assign mem_wr = wr_reg;
    assign watchdog_clear = wdt_clr_reg;
    assign timeout_flag = timeout_reg;
    assign powerdown_flag = powerdown_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_call_push_addr: assert property (
        accept && instr.op == exec_pkg::OP_CALL |=> stack_push
            && stack_data == $past(instr.pc) + exec_pkg::RET_STEP)
        else $error("Call did not push the return address.");

    a_call_load_target: assert property (
        accept && instr.op == exec_pkg::OP_CALL |=> ##1 pc_load
            && pc_target == $past(instr.target, 2))
        else $error("Call did not load the target.");

    a_call_two_cycles: assert property (
        stack_push |-> busy && !pc_load ##1 pc_load && !busy)
        else $error("Call did not take two cycles.");

    a_byte_clear_write: assert property (
        accept && instr.op == exec_pkg::OP_CLR_BYTE |=> mem_wr.en
            && mem_wr.mask == exec_pkg::FULL_MASK && mem_wr.data == exec_pkg::CLEAR_BYTE
            && !watchdog_clear)
        else $error("Byte clear wrong.");

    a_bit_clear_mask: assert property (
        accept && instr.op == exec_pkg::OP_CLR_BIT |=> mem_wr.en
            && mem_wr.mask == (exec_pkg::BIT0_MASK << $past(instr.bitsel))
            && mem_wr.addr == $past(instr.addr))
        else $error("Bit clear mask wrong.");

    a_single_clear_flags: assert property (
        accept && instr.op == exec_pkg::OP_WDT_SINGLE && !timeout_set && !powerdown_set
            |=> watchdog_clear && !timeout_flag && !powerdown_flag)
        else $error("Single clear did not clear.");

    // Reference of the last unmatched pre-clear half, kept apart from the tracker.
    exec_pkg::pre_state_t ref_half_reg;
    exec_pkg::pre_state_t ref_half_next;
    logic ref_pair;
    assign ref_pair = (first_strobe && ref_half_reg == exec_pkg::PRE_SECOND)
        || (second_strobe && ref_half_reg == exec_pkg::PRE_FIRST);

    // The opposite half empties the reference; any other half arms it.
    always_comb begin
        ref_half_next = ref_half_reg;
        if (ref_pair) begin
            ref_half_next = exec_pkg::PRE_NONE;
        end else if (first_strobe) begin
            ref_half_next = exec_pkg::PRE_FIRST;
        end else if (second_strobe) begin
            ref_half_next = exec_pkg::PRE_SECOND;
        end
    end

    // Registers the reference; reset empties it.
    always_ff @(posedge clk) begin
        ref_half_reg <= reset_n ? ref_half_next : exec_pkg::PRE_NONE;
    end

    a_first_after_second: assert property (first_strobe && ref_pair |=> watchdog_clear)
        else $error("Alternating first half did not clear.");

    a_second_after_first: assert property (second_strobe && ref_pair |=> watchdog_clear)
        else $error("Alternating second half did not clear.");

    a_repeat_no_effect: assert property (
        (first_strobe || second_strobe) && !ref_pair |=> !watchdog_clear)
        else $error("Repeated pre-clear had an effect.");

    a_flags_hold: assert property (
        !clear_req && !timeout_set |=> timeout_flag == $past(timeout_flag))
        else $error("Time-out flag changed without cause.");

    c_call_seen: cover property (stack_push ##1 pc_load);
    c_pair_clear: cover property (first_strobe ##[1:4] second_strobe);
    c_bit_clear: cover property (mem_wr.en && mem_wr.mask != exec_pkg::FULL_MASK);
    c_set_wins: cover property (clear_req && timeout_set);

endmodule : call_clear_watchdog_exec

`default_nettype wire

// >>> rtl/exec_pkg.sv
package exec_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------

    // Program counter width, enough for a 2048-word program store.
    localparam int PC_W = 11;
    // Data memory address and data widths.
    localparam int DADDR_W = 8;
    localparam int DATA_W = 8;
    // Width of the bit selector within a data byte.
    localparam int BITSEL_W = 3;

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------

    // Step from the current instruction to the return address.
    localparam logic [PC_W-1:0] RET_STEP = 11'h001;
    // Value written by a byte clear.
    localparam logic [DATA_W-1:0] CLEAR_BYTE = 8'h00;
    // Mask covering every bit of a byte.
    localparam logic [DATA_W-1:0] FULL_MASK = 8'hFF;
    // Mask for bit 0, shifted to pick a single bit.
    localparam logic [DATA_W-1:0] BIT0_MASK = 8'h01;
    // Flag reset values.
    localparam logic FLAG_RESET = 1'b0;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------

    // Instruction group handled by this unit.
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_CALL = 3'b001,
        OP_CLR_BYTE = 3'b010,
        OP_CLR_BIT = 3'b011,
        OP_WDT_SINGLE = 3'b100,
        OP_WDT_FIRST = 3'b101,
        OP_WDT_SECOND = 3'b110
    } op_t;

    // Execution sequencer states.
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CALL2 = 1'b1
    } exec_state_t;

    // Which pre-clear ran last without its partner.
    typedef enum logic [1:0] {
        PRE_NONE = 2'b00,
        PRE_FIRST = 2'b01,
        PRE_SECOND = 2'b10
    } pre_state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------

    // Decoded instruction from the decode stage.
    typedef struct packed {
        logic valid;
        op_t op;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] target;
        logic [DADDR_W-1:0] addr;
        logic [BITSEL_W-1:0] bitsel;
    } instr_t;

    // Masked write toward data memory.
    typedef struct packed {
        logic en;
        logic [DADDR_W-1:0] addr;
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] data;
    } mem_wr_t;

endpackage : exec_pkg

// >>> rtl/preclear_tracker.sv
`timescale 1ns/10ps
`default_nettype none

module preclear_tracker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pre-clear strobes, one cycle each
    input wire logic first_strobe,
    input wire logic second_strobe,
    // Pair completed this cycle
    output logic pair_done
);

    // ------------------------------------------------------------------
    // Tracking state
    // ------------------------------------------------------------------

    // Remembers the half of the pair that ran last without its partner.
    exec_pkg::pre_state_t pre_reg;
    exec_pkg::pre_state_t pre_next;

    // Next state and completion. Other instructions leave the state alone.
    always_comb begin
        pre_next = pre_reg;
        pair_done = 1'b0;
        if (first_strobe) begin
            if (pre_reg == exec_pkg::PRE_SECOND) begin
                pair_done = 1'b1;
                pre_next = exec_pkg::PRE_NONE;
            end else begin
                // repeat only re-arms
                // A repeated first half only re-arms; it clears nothing.
                pre_next = exec_pkg::PRE_FIRST;
            end
        end else if (second_strobe) begin
            if (pre_reg == exec_pkg::PRE_FIRST) begin
                pair_done = 1'b1;
                pre_next = exec_pkg::PRE_NONE;
            end else begin
                pre_next = exec_pkg::PRE_SECOND;
            end
        end
    end

    // Registers the tracking state.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pre_reg <= exec_pkg::PRE_NONE;
        end else begin
            pre_reg <= pre_next;
        end
    end

endmodule : preclear_tracker

`default_nettype wire

// >>> sim/call_clear_watchdog_exec_test.sv
`timescale 1ns/10ps
`default_nettype none

module call_clear_watchdog_exec_test;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------

    // Clock and synchronous reset, low while asserted.
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    // Decoded instruction and flag set events driven by the bench.
    exec_pkg::instr_t instr = '0;
    logic timeout_set = 1'b0;
    logic powerdown_set = 1'b0;
    // Outputs of the unit under test.
    logic busy;
    logic stack_push;
    logic [exec_pkg::PC_W-1:0] stack_data;
    logic pc_load;
    logic [exec_pkg::PC_W-1:0] pc_target;
    exec_pkg::mem_wr_t mem_wr;
    logic watchdog_clear;
    logic timeout_flag;
    logic powerdown_flag;
    // Tallies of mismatches and comparisons.
    int errors = 0;
    int comparisons = 0;

    // A 10 ns period; inputs change on the falling edge only.
    always #5 clk = ~clk;

    call_clear_watchdog_exec i_dut (
        .clk(clk),
        .reset_n(reset_n),
        .instr(instr),
        .timeout_set(timeout_set),
        .powerdown_set(powerdown_set),
        .busy(busy),
        .stack_push(stack_push),
        .stack_data(stack_data),
        .pc_load(pc_load),
        .pc_target(pc_target),
        .mem_wr(mem_wr),
        .watchdog_clear(watchdog_clear),
        .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------

    // Compares with case equality so that an unknown never matches.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Offers one instruction and returns at the next falling edge, taken or not.
    task automatic issue(input exec_pkg::op_t op, input logic [10:0] pc,
                         input logic [10:0] tgt, input logic [7:0] addr,
                         input logic [2:0] bitsel);
        instr = '{valid: 1'b1, op: op, pc: pc, target: tgt, addr: addr, bitsel: bitsel};
        @(negedge clk);
    endtask : issue

    // Withdraws the offer and lets one cycle pass.
    task automatic idle();
        instr.valid = 1'b0;
        @(negedge clk);
    endtask : idle

    // Raises both flags with a one-cycle set pulse.
    task automatic set_flags();
        timeout_set = 1'b1;
        powerdown_set = 1'b1;
        @(negedge clk);
        timeout_set = 1'b0;
        powerdown_set = 1'b0;
    endtask : set_flags

    // Checks the watchdog clear strobe and both flag levels together.
    task automatic wdt_is(input logic wc, input logic fl);
        check(16'(watchdog_clear), 16'(wc));
        check(16'(timeout_flag), 16'(fl));
        check(16'(powerdown_flag), 16'(fl));
    endtask : wdt_is

    // Closing report, reached from the main sequence or the time limit.
    task automatic wrap_up();
        $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------

    // A call at the top of the program store, with an offer made while busy.
    task automatic test_call();
        issue(exec_pkg::OP_CALL, 11'h7FF, 11'h123, 8'h00, 3'h0);
        check(16'(stack_push), 16'h0001);
        check(16'(stack_data), 16'h0000);
        check(16'(busy), 16'h0001);
        check(16'(pc_load), 16'h0000);
        // The second cycle refuses this byte clear.
        issue(exec_pkg::OP_CLR_BYTE, 11'h000, 11'h000, 8'h55, 3'h0);
        check(16'(pc_load), 16'h0001);
        check(16'(pc_target), 16'h0123);
        check(16'(stack_push), 16'h0000);
        check(16'(busy), 16'h0000);
        check(16'(mem_wr.en), 16'h0000);
        wdt_is(1'b0, 1'b1);
        idle();
        check(16'(pc_load), 16'h0000);
        $display("test call done");
    endtask : test_call

    // A byte clear followed back to back by a bit clear at every position.
    task automatic test_clear();
        issue(exec_pkg::OP_CLR_BYTE, 11'h000, 11'h000, 8'hA5, 3'h0);
        check(16'(mem_wr), 16'({1'b1, 8'hA5, 8'hFF, 8'h00}));
        check(16'(mem_wr >> 16), 16'h01A5);
        wdt_is(1'b0, 1'b1);
        for (int b = 0; b < 8; b++) begin
            issue(exec_pkg::OP_CLR_BIT, 11'h000, 11'h000, 8'(8'h10 + b), 3'(b));
            check(16'(mem_wr), 16'({1'b1, 8'(8'h10 + b), 8'(8'h01 << b), 8'h00}));
            check(16'(mem_wr >> 16), 16'({1'b1, 8'(8'h10 + b)}));
            check(16'(timeout_flag), 16'h0001);
        end
        idle();
        check(16'(mem_wr.en), 16'h0000);
        $display("test clear done");
    endtask : test_clear

    // The single clear acts at once on the counter and both flags.
    task automatic test_single();
        issue(exec_pkg::OP_WDT_SINGLE, 11'h000, 11'h000, 8'h00, 3'h0);
        wdt_is(1'b1, 1'b0);
        idle();
        wdt_is(1'b0, 1'b0);
        $display("test single done");
    endtask : test_single

    // Pre-clears in both orders, with repeats and unrelated work between.
    task automatic test_pair();
        set_flags();
        issue(exec_pkg::OP_WDT_FIRST, 11'h000, 11'h000, 8'h00, 3'h0);
        wdt_is(1'b0, 1'b1);
        issue(exec_pkg::OP_WDT_FIRST, 11'h000, 11'h000, 8'h00, 3'h0);
        wdt_is(1'b0, 1'b1);
        issue(exec_pkg::OP_CLR_BYTE, 11'h000, 11'h000, 8'h20, 3'h0);
        wdt_is(1'b0, 1'b1);
        issue(exec_pkg::OP_WDT_SECOND, 11'h000, 11'h000, 8'h00, 3'h0);
        wdt_is(1'b1, 1'b0);
        idle();
        set_flags();
        issue(exec_pkg::OP_WDT_SECOND, 11'h000, 11'h000, 8'h00, 3'h0);
        issue(exec_pkg::OP_WDT_SECOND, 11'h000, 11'h000, 8'h00, 3'h0);
        wdt_is(1'b0, 1'b1);
        issue(exec_pkg::OP_WDT_FIRST, 11'h000, 11'h000, 8'h00, 3'h0);
        wdt_is(1'b1, 1'b0);
        idle();
        set_flags();
        // After completion the tracking starts over, so this one waits.
        issue(exec_pkg::OP_WDT_FIRST, 11'h000, 11'h000, 8'h00, 3'h0);
        wdt_is(1'b0, 1'b1);
        issue(exec_pkg::OP_WDT_SINGLE, 11'h000, 11'h000, 8'h00, 3'h0);
        wdt_is(1'b1, 1'b0);
        // The single clear still offered meets the set pulse; the set wins.
        set_flags();
        wdt_is(1'b1, 1'b1);
        issue(exec_pkg::OP_WDT_SECOND, 11'h000, 11'h000, 8'h00, 3'h0);
        wdt_is(1'b1, 1'b0);
        idle();
        $display("test pair done");
    endtask : test_pair

    // ------------------------------------------------------------------
    // Main sequence and time limit
    // ------------------------------------------------------------------

    // A hang would otherwise run forever; this limit counts as a mismatch.
    initial begin
        #100000;
        errors++;
        $display("Error at %0t: run time limit reached", $time);
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        check(16'(stack_push), 16'h0000);
        wdt_is(1'b0, 1'b0);
        set_flags();
        test_call();
        test_clear();
        test_single();
        test_pair();
        wrap_up();
    end

endmodule : call_clear_watchdog_exec_test

`default_nettype wire
